// ### bit_manipulation_pkg.sv
/*
 * Constants, operation codes and decode functions for the single-bit
 * instruction unit. Assumes the unit runs on one clock with a synchronous,
 * active-high reset and a byte-wide memory bus on that same clock.
 */
// Operation
// RULE1: Set forces the selected byte bit to 1, others unchanged.
// RULE2: Set, clear, invert, test take position from immediate or register low bits.
// RULE3: Clear forces the selected byte bit to 0, others unchanged.
// RULE4: Invert complements the selected bit, other bits untouched.
// RULE5: Test loads zero flag with inverse of selected bit; operand kept.
// RULE6: Carry becomes carry AND selected bit.
// RULE7: Carry becomes carry AND inverse of selected bit.
// RULE8: Carry becomes carry OR selected bit.
// RULE9: Carry becomes carry OR inverse of selected bit.
// RULE10: Carry becomes carry XOR selected bit.
// RULE11: Carry becomes carry XOR inverse of selected bit.
// RULE12: Carry-combine, load and store take position from immediate field only.
// RULE13: Bit load copies selected bit into carry; operand kept.
// RULE14: Inverted bit load puts inverse of selected bit into carry.
// RULE15: Bit store writes carry into the selected bit.
// RULE16: Inverted bit store writes inverse of carry into the selected bit.
// RULE17: Set, clear, invert, stores are whole-byte read-modify-write.
// RULE18: Memory operand: read at address, modify one bit, write same address.
// RULE19: Write-only target reads as all ones, so unmodified bits become 1.
// RULE20: Test, carry-combine and carry-load issue no operand write.
// RULE21: Operand is one byte; bit 0 least, bit 7 most significant.
package bit_manipulation_pkg;

	// ----------------------------------------------------------------
	// Widths and fixed values
	// ----------------------------------------------------------------
	localparam int          BYTE_W       = 8;
	localparam int          POS_W        = 3;
	localparam int          ADDR_W       = 16;
	localparam logic [7:0]  WRITE_ONLY_READ = 8'hFF;
	localparam logic [7:0]  DATA_RESET   = 8'h00;
	localparam logic [15:0] ADDR_RESET   = 16'h0000;
	localparam logic [2:0]  POS_RESET    = 3'h0;

	// ----------------------------------------------------------------
	// Operations
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		bit_set_op          = 4'h0,
		bit_clear_op        = 4'h1,
		bit_invert_op       = 4'h2,
		bit_test_op         = 4'h3,
		carry_and_bit_op    = 4'h4,
		carry_and_notbit_op = 4'h5,
		carry_or_bit_op     = 4'h6,
		carry_or_notbit_op  = 4'h7,
		carry_xor_bit_op    = 4'h8,
		carry_xor_notbit_op = 4'h9,
		bit_to_carry_op     = 4'hA,
		notbit_to_carry_op  = 4'hB,
		carry_to_bit_op     = 4'hC,
		notcarry_to_bit_op  = 4'hD
	} op_t;

	// Ops that rewrite the operand byte
	function automatic logic op_writes_byte(input op_t op);
		op_writes_byte = (op == bit_set_op) || (op == bit_clear_op) ||
			(op == bit_invert_op) || (op == carry_to_bit_op) ||
			(op == notcarry_to_bit_op); // see RULE17 see RULE20
	endfunction : op_writes_byte

	// Ops that may take the position from a register
	function automatic logic op_reg_position(input op_t op);
		op_reg_position = (op == bit_set_op) || (op == bit_clear_op) ||
			(op == bit_invert_op) || (op == bit_test_op); // see RULE2 see RULE12
	endfunction : op_reg_position

endpackage : bit_manipulation_pkg

// ### bit_position_select.sv
/*
 * Picks the bit number for a single-bit operation.
 * Assumes the register value is the live content of the named register.
 */
`timescale 1ns/1ps
`default_nettype none
module bit_position_select (
	// Operation
	input  wire bit_manipulation_pkg::op_t op,
	input  wire logic                      pos_from_reg,
	// Sources
	input  wire logic [2:0]                imm_pos,
	input  wire logic [7:0]                reg_pos_value,
	// Result
	output logic      [2:0]                bit_pos
);
	// ----------------------------------------------------------------
	// Selection
	// ----------------------------------------------------------------
	// Carry ops ignore the register flag rather than fault on it
	always_comb begin
		if (pos_from_reg && bit_manipulation_pkg::op_reg_position(op)) begin
			bit_pos = reg_pos_value[2:0]; // see RULE2
		end else begin
			bit_pos = imm_pos; // see RULE12
		end
	end
endmodule : bit_position_select
`default_nettype wire

// ### bit_operation_alu.sv
/*
 * Combinational core: new byte and flag values for one bit operation.
 * Assumes operand byte and carry are stable while the result is used.
 */
`timescale 1ns/1ps
`default_nettype none
module bit_operation_alu (
	// Operands
	input  wire bit_manipulation_pkg::op_t op,
	input  wire logic [7:0]                data_in,
	input  wire logic [2:0]                bit_pos,
	input  wire logic                      carry_in,
	// Results
	output logic      [7:0]                data_out,
	output logic                           carry_out,
	output logic                           carry_update,
	output logic                           zero_out,
	output logic                           zero_update
);
	logic [7:0] mask;
	logic       sel;

	// ----------------------------------------------------------------
	// Bit arithmetic
	// ----------------------------------------------------------------
	always_comb begin
		mask         = 8'h01 << bit_pos; // see RULE21
		sel          = data_in[bit_pos];
		data_out     = data_in;
		carry_out    = carry_in;
		carry_update = 1'b0;
		zero_out     = 1'b0;
		zero_update  = 1'b0;
		unique case (op)
			bit_manipulation_pkg::bit_set_op:          data_out = data_in | mask;  // see RULE1
			bit_manipulation_pkg::bit_clear_op:        data_out = data_in & ~mask; // see RULE3
			bit_manipulation_pkg::bit_invert_op:       data_out = data_in ^ mask;  // see RULE4
			bit_manipulation_pkg::bit_test_op: begin
				zero_out    = ~sel; // see RULE5
				zero_update = 1'b1;
			end
			bit_manipulation_pkg::carry_and_bit_op: begin
				carry_out    = carry_in & sel; // see RULE6
				carry_update = 1'b1;
			end
			bit_manipulation_pkg::carry_and_notbit_op: begin
				carry_out    = carry_in & ~sel; // see RULE7
				carry_update = 1'b1;
			end
			bit_manipulation_pkg::carry_or_bit_op: begin
				carry_out    = carry_in | sel; // see RULE8
				carry_update = 1'b1;
			end
			bit_manipulation_pkg::carry_or_notbit_op: begin
				carry_out    = carry_in | ~sel; // see RULE9
				carry_update = 1'b1;
			end
			bit_manipulation_pkg::carry_xor_bit_op: begin
				carry_out    = carry_in ^ sel; // see RULE10
				carry_update = 1'b1;
			end
			bit_manipulation_pkg::carry_xor_notbit_op: begin
				carry_out    = carry_in ^ ~sel; // see RULE11
				carry_update = 1'b1;
			end
			bit_manipulation_pkg::bit_to_carry_op: begin
				carry_out    = sel; // see RULE13
				carry_update = 1'b1;
			end
			bit_manipulation_pkg::notbit_to_carry_op: begin
				carry_out    = ~sel; // see RULE14
				carry_update = 1'b1;
			end
			bit_manipulation_pkg::carry_to_bit_op:
				data_out = carry_in ? (data_in | mask) : (data_in & ~mask); // see RULE15
			bit_manipulation_pkg::notcarry_to_bit_op:
				data_out = carry_in ? (data_in & ~mask) : (data_in | mask); // see RULE16
			default: data_out = data_in;
		endcase
	end
endmodule : bit_operation_alu
`default_nettype wire

// ### bit_manipulation_unit.sv
/*
 * Single-bit instruction unit: sequences one operation on a byte held in
 * a general register or in memory, with read-modify-write on the bus.
 * Assumes the bus slave answers each read or write with a one-cycle ack,
 * and flags it when the addressed location is write-only.
 */
`timescale 1ns/1ps
`default_nettype none
module bit_manipulation_unit #(
	parameter int ADDR_W = bit_manipulation_pkg::ADDR_W
) (
	// Clock and reset
	input  wire logic                      clock,
	input  wire logic                      rst,
	// Instruction request
	input  wire logic                      start,
	input  wire bit_manipulation_pkg::op_t op,
	input  wire logic                      pos_from_reg,
	input  wire logic [2:0]                imm_pos,
	input  wire logic [7:0]                reg_pos_value,
	input  wire logic                      operand_in_mem,
	input  wire logic [7:0]                reg_operand,
	input  wire logic [ADDR_W-1:0]         operand_addr,
	input  wire logic                      carry_flag,
	output logic                           ready,
	output logic                           done,
	// Register write-back
	output logic      [7:0]                reg_result,
	output logic                           reg_write,
	// Flag updates
	output logic                           carry_result,
	output logic                           carry_write,
	output logic                           zero_result,
	output logic                           zero_write,
	// Memory bus
	output logic                           mem_read,
	output logic                           mem_write,
	output logic      [ADDR_W-1:0]         mem_addr,
	output logic      [7:0]                mem_wdata,
	input  wire logic [7:0]                mem_rdata,
	input  wire logic                      mem_write_only,
	input  wire logic                      mem_ack
);
	// ----------------------------------------------------------------
	// Elaboration check
	// ----------------------------------------------------------------
	if (ADDR_W < 1 || ADDR_W > 32) begin : g_bad_addr
		$error("ADDR_W must lie between 1 and 32");
	end

	typedef enum logic [1:0] {st_idle, st_read, st_modify, st_write} state_t;

	state_t                    state, next_state;
	bit_manipulation_pkg::op_t cur_op, next_cur_op;
	logic [2:0]                cur_pos, next_cur_pos;
	logic                      cur_mem, next_cur_mem;
	logic                      cur_carry, next_cur_carry;
	logic [7:0]                data, next_data;
	logic                      next_ready, next_done, next_reg_write;
	logic [7:0]                next_reg_result, next_mem_wdata;
	logic                      next_carry_result, next_carry_write;
	logic                      next_zero_result, next_zero_write;
	logic                      next_mem_read, next_mem_write;
	logic [ADDR_W-1:0]         next_mem_addr;
	logic [2:0]                sel_pos;
	logic [7:0]                alu_data;
	logic                      alu_carry, alu_carry_upd, alu_zero, alu_zero_upd;

	// ----------------------------------------------------------------
	// Datapath
	// ----------------------------------------------------------------
	bit_position_select u_pos (
		.op            (op),
		.pos_from_reg  (pos_from_reg),
		.imm_pos       (imm_pos),
		.reg_pos_value (reg_pos_value),
		.bit_pos       (sel_pos)
	);

	bit_operation_alu u_alu (
		.op           (cur_op),
		.data_in      (data),
		.bit_pos      (cur_pos),
		.carry_in     (cur_carry),
		.data_out     (alu_data),
		.carry_out    (alu_carry),
		.carry_update (alu_carry_upd),
		.zero_out     (alu_zero),
		.zero_update  (alu_zero_upd)
	);

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	always_comb begin
		next_state        = state;
		next_cur_op       = cur_op;
		next_cur_pos      = cur_pos;
		next_cur_mem      = cur_mem;
		next_cur_carry    = cur_carry;
		next_data         = data;
		next_ready        = ready;
		next_done         = 1'b0;
		next_reg_result   = reg_result;
		next_reg_write    = 1'b0;
		next_carry_result = carry_result;
		next_carry_write  = 1'b0;
		next_zero_result  = zero_result;
		next_zero_write   = 1'b0;
		next_mem_read     = mem_read;
		next_mem_write    = mem_write;
		next_mem_addr     = mem_addr;
		next_mem_wdata    = mem_wdata;
		unique case (state)
			st_idle: begin
				if (start) begin
					next_cur_op    = op;
					next_cur_pos   = sel_pos;
					next_cur_mem   = operand_in_mem;
					next_cur_carry = carry_flag;
					next_ready     = 1'b0;
					if (operand_in_mem) begin
						next_mem_read = 1'b1; // see RULE18
						next_mem_addr = operand_addr;
						next_state    = st_read;
					end else begin
						next_data  = reg_operand;
						next_state = st_modify;
					end
				end
			end
			st_read: begin
				if (mem_ack) begin
					next_mem_read = 1'b0;
					// Write-only location cannot echo its content
					next_data  = mem_write_only ? bit_manipulation_pkg::WRITE_ONLY_READ
						: mem_rdata; // see RULE19
					next_state = st_modify;
				end
			end
			st_modify: begin
				next_carry_result = alu_carry_upd ? alu_carry : carry_result;
				next_carry_write  = alu_carry_upd;
				next_zero_result  = alu_zero_upd ? alu_zero : zero_result;
				next_zero_write   = alu_zero_upd;
				if (bit_manipulation_pkg::op_writes_byte(cur_op) && cur_mem) begin
					next_mem_write = 1'b1; // see RULE17 see RULE18
					next_mem_wdata = alu_data;
					next_state     = st_write;
				end else begin
					if (bit_manipulation_pkg::op_writes_byte(cur_op)) begin
						next_reg_result = alu_data; // see RULE17
						next_reg_write  = 1'b1;
					end
					next_done  = 1'b1; // see RULE20
					next_ready = 1'b1;
					next_state = st_idle;
				end
			end
			st_write: begin
				if (mem_ack) begin
					next_mem_write = 1'b0;
					next_done      = 1'b1;
					next_ready     = 1'b1;
					next_state     = st_idle;
				end
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			state        <= st_idle;
			cur_op       <= bit_manipulation_pkg::bit_set_op;
			cur_pos      <= bit_manipulation_pkg::POS_RESET;
			cur_mem      <= 1'b0;
			cur_carry    <= 1'b0;
			data         <= bit_manipulation_pkg::DATA_RESET;
			ready        <= 1'b1;
			done         <= 1'b0;
			reg_result   <= bit_manipulation_pkg::DATA_RESET;
			reg_write    <= 1'b0;
			carry_result <= 1'b0;
			carry_write  <= 1'b0;
			zero_result  <= 1'b0;
			zero_write   <= 1'b0;
			mem_read     <= 1'b0;
			mem_write    <= 1'b0;
			mem_addr     <= '0;
			mem_wdata    <= bit_manipulation_pkg::DATA_RESET;
		end else begin
			state        <= next_state;
			cur_op       <= next_cur_op;
			cur_pos      <= next_cur_pos;
			cur_mem      <= next_cur_mem;
			cur_carry    <= next_cur_carry;
			data         <= next_data;
			ready        <= next_ready;
			done         <= next_done;
			reg_result   <= next_reg_result;
			reg_write    <= next_reg_write;
			carry_result <= next_carry_result;
			carry_write  <= next_carry_write;
			zero_result  <= next_zero_result;
			zero_write   <= next_zero_write;
			mem_read     <= next_mem_read;
			mem_write    <= next_mem_write;
			mem_addr     <= next_mem_addr;
			mem_wdata    <= next_mem_wdata;
		end
	end
endmodule : bit_manipulation_unit
`default_nettype wire

// ### bit_memory_model.sv
/* Byte memory with one write-only location, standing behind the bit unit.
   Assumes addresses below 256 and a bench that drives slow. */
`timescale 1ns/1ps
`default_nettype none
module bit_memory_model #(
	parameter logic [7:0] WO_ADDR = 8'h30
) (
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic        slow,
	// Bus from the unit
	input  wire logic        mem_read,
	input  wire logic        mem_write,
	input  wire logic [15:0] mem_addr,
	input  wire logic [7:0]  mem_wdata,
	output logic      [7:0]  mem_rdata,
	output logic             mem_write_only,
	output logic             mem_ack
);
	logic [7:0] store [0:255];
	int         writes;
	int         wait_n;
	logic [7:0] a;

	assign a = mem_addr[7:0];
	always_ff @(posedge clock) begin
		mem_ack <= 1'b0;
		mem_write_only <= 1'b0;
		if (rst) begin
			for (int i = 0; i < 256; i++) store[i] <= 8'(i) ^ 8'hA5;
			store[WO_ADDR] <= 8'h3F;
			writes <= 0;
			wait_n <= 0;
			mem_rdata <= 8'h00;
		end else if ((mem_read || mem_write) && !mem_ack) begin
			if (wait_n >= (slow ? 3 : 0)) begin
				// No second ack while the unit drops the strobe
				mem_ack <= 1'b1;
				wait_n <= 0;
				mem_write_only <= (a == WO_ADDR);
				mem_rdata <= (a == WO_ADDR) ? ~store[a] : store[a];
				if (mem_write) begin
					store[a] <= mem_wdata;
					writes <= writes + 1;
				end
			end else begin
				wait_n <= wait_n + 1;
			end
		end else begin
			// Released data lines keep changing, never the last value
			mem_rdata <= ~mem_rdata;
		end
	end
endmodule : bit_memory_model
`default_nettype wire

// ### bit_manipulation_unit_monitor.sv
/* Checker for bus order and per-bit results of the bit unit.
   Assumes it is bound into every bit_manipulation_unit instance. */
`timescale 1ns/1ps
`default_nettype none
module bit_manipulation_unit_monitor #(
	parameter int ADDR_W = 16
) (
	// Request side
	input  wire logic                      clock,
	input  wire logic                      rst,
	input  wire logic                      start,
	input  wire bit_manipulation_pkg::op_t op,
	input  wire logic                      pos_from_reg,
	input  wire logic [2:0]                imm_pos,
	input  wire logic [7:0]                reg_pos_value,
	input  wire logic                      operand_in_mem,
	input  wire logic                      ready,
	input  wire logic                      done,
	input  wire logic                      reg_write,
	input  wire logic                      zero_write,
	// Bus side
	input  wire logic                      mem_read,
	input  wire logic                      mem_write,
	input  wire logic [ADDR_W-1:0]         mem_addr,
	input  wire logic [7:0]                mem_wdata,
	input  wire logic [7:0]                mem_rdata,
	input  wire logic                      mem_write_only,
	input  wire logic                      mem_ack
);
	bit_manipulation_pkg::op_t lop;
	logic [2:0]                lpos;
	logic [ADDR_W-1:0]         raddr;
	logic [7:0]                rbyte;
	logic [7:0]                mask;

	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	assign mask = 8'h01 << lpos;
	always_ff @(posedge clock) begin
		if (start && ready) begin
			lop <= op;
			lpos <= (pos_from_reg && op <= bit_manipulation_pkg::bit_test_op) ?
				reg_pos_value[2:0] : imm_pos;
		end
		if (mem_read && mem_ack) begin
			raddr <= mem_addr;
			rbyte <= mem_write_only ? 8'hFF : mem_rdata;
		end
	end

	a_read_excl_write: assert property (mem_read |-> !mem_write)
		else $error("read and write strobes together");
	a_write_same_addr: assert property ($rose(mem_write) |-> mem_addr == raddr)
		else $error("write address differs from read address");
	a_strobe_hold: assert property ((mem_read || mem_write) && !mem_ack |=>
		(mem_read || mem_write) && $stable(mem_addr) && $stable(mem_wdata))
		else $error("bus request changed before ack");
	a_strobe_drop: assert property ((mem_read || mem_write) && mem_ack |=>
		!mem_read && !mem_write)
		else $error("strobe not dropped after ack");
	a_one_bit_change: assert property ($rose(mem_write) |->
		((mem_wdata ^ rbyte) & ~mask) == 8'h00)
		else $error("written byte differs outside selected bit");
	a_set_bit_one: assert property ($rose(mem_write) &&
		lop == bit_manipulation_pkg::bit_set_op |-> mem_wdata[lpos])
		else $error("set left bit low");
	a_clear_bit_zero: assert property ($rose(mem_write) &&
		lop == bit_manipulation_pkg::bit_clear_op |-> !mem_wdata[lpos])
		else $error("clear left bit high");
	a_invert_bit_flip: assert property ($rose(mem_write) &&
		lop == bit_manipulation_pkg::bit_invert_op |-> mem_wdata[lpos] != rbyte[lpos])
		else $error("invert did not flip bit");
	a_no_write_ops: assert property ($rose(mem_write) || reg_write |->
		lop <= bit_manipulation_pkg::bit_invert_op ||
		lop >= bit_manipulation_pkg::carry_to_bit_op)
		else $error("operand written by a read-only op");
	a_reg_latency: assert property (start && ready && !operand_in_mem |-> ##2 done)
		else $error("register op not done in two cycles");
	a_test_zero_only: assert property (zero_write |-> lop == bit_manipulation_pkg::bit_test_op)
		else $error("zero flag written by non-test op");

	c_mem_rmw: cover property ($rose(mem_write));
	c_write_only: cover property (mem_read && mem_ack && mem_write_only);
	c_test_op: cover property (zero_write);
endmodule : bit_manipulation_unit_monitor
`default_nettype wire

bind bit_manipulation_unit bit_manipulation_unit_monitor #(.ADDR_W(ADDR_W)) monitor_inst (
	.clock, .rst, .start, .op, .pos_from_reg, .imm_pos, .reg_pos_value, .operand_in_mem,
	.ready, .done, .reg_write, .zero_write, .mem_read, .mem_write, .mem_addr, .mem_wdata,
	.mem_rdata, .mem_write_only, .mem_ack);

// ### bit_manipulation_unit_tb.sv
/* Self-checking bench for the bit unit, register and memory operands.
   Assumes the memory model's write-only location at 8'h30. */
`timescale 1ns/1ps
`default_nettype none
module bit_manipulation_unit_tb;
	logic clock = 1'b0, rst = 1'b1, start = 1'b0, pos_from_reg = 1'b0, slow = 1'b0;
	logic operand_in_mem = 1'b0, carry_flag = 1'b0;
	bit_manipulation_pkg::op_t op = bit_manipulation_pkg::bit_set_op;
	logic [2:0]  imm_pos = 3'h0;
	logic [7:0]  reg_pos_value = 8'h00, reg_operand = 8'h00, reg_result, mem_wdata, mem_rdata;
	logic [15:0] operand_addr = 16'h0000, mem_addr;
	logic ready, done, reg_write, carry_result, carry_write, zero_result, zero_write;
	logic mem_read, mem_write, mem_write_only, mem_ack;
	int   mismatches = 0, checks_done = 0;

	bit_manipulation_unit bit_manipulation_unit_inst (.clock, .rst, .start, .op, .pos_from_reg,
		.imm_pos, .reg_pos_value, .operand_in_mem, .reg_operand, .operand_addr, .carry_flag,
		.ready, .done, .reg_result, .reg_write, .carry_result, .carry_write, .zero_result,
		.zero_write, .mem_read, .mem_write, .mem_addr, .mem_wdata, .mem_rdata,
		.mem_write_only, .mem_ack);
	bit_memory_model bit_memory_model_inst (.clock, .rst, .slow, .mem_read, .mem_write,
		.mem_addr, .mem_wdata, .mem_rdata, .mem_write_only, .mem_ack);

	initial begin
		forever #4 clock = ~clock;
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic report_and_stop;
		$display("checks=%0d mismatches=%0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : report_and_stop

	// Returns {byte write, carry write, new carry, zero write, new zero, new byte}
	function automatic logic [12:0] predict(input int o, input logic [7:0] d,
		input logic [2:0] p, input logic c);
		logic       b;
		logic [7:0] m;
		b = d[p];
		m = 8'h01 << p;
		case (o)
			0: predict = {5'h10, d | m};
			1: predict = {5'h10, d & ~m};
			2: predict = {5'h10, d ^ m};
			3: predict = {4'h1, ~b, d};
			4: predict = {2'b01, c & b, 2'b00, d};
			5: predict = {2'b01, c & ~b, 2'b00, d};
			6: predict = {2'b01, c | b, 2'b00, d};
			7: predict = {2'b01, c | ~b, 2'b00, d};
			8: predict = {2'b01, c ^ b, 2'b00, d};
			9: predict = {2'b01, c ^ ~b, 2'b00, d};
			10: predict = {2'b01, b, 2'b00, d};
			11: predict = {2'b01, ~b, 2'b00, d};
			12: predict = {5'h10, (d & ~m) | (c ? m : 8'h00)};
			default: predict = {5'h10, (d & ~m) | (c ? 8'h00 : m)};
		endcase
	endfunction : predict

	// One operation; d is the byte the unit should read
	task automatic run_op(input int o, input logic fr, input logic [2:0] ip,
		input logic [2:0] rp, input logic mem, input logic [7:0] d, input logic [7:0] a,
		input logic c);
		logic [12:0] e;
		int          n;
		int          w0;
		e = predict(o, d, (fr && o < 4) ? rp : ip, c);
		w0 = bit_memory_model_inst.writes;
		@(posedge clock);
		start <= 1'b1;
		op <= bit_manipulation_pkg::op_t'(o);
		pos_from_reg <= fr;
		imm_pos <= ip;
		reg_pos_value <= {5'h15, rp};
		operand_in_mem <= mem;
		reg_operand <= d;
		operand_addr <= {8'h00, a};
		carry_flag <= c;
		@(posedge clock);
		start <= 1'b0;
		n = 0;
		#1;
		while (done !== 1'b1 && n < 40) begin
			@(posedge clock);
			#1;
			n++;
		end
		check({7'h00, done}, 8'h01);
		check({7'h00, carry_write}, {7'h00, e[11]});
		if (e[11]) check({7'h00, carry_result}, {7'h00, e[10]});
		check({7'h00, zero_write}, {7'h00, e[9]});
		if (e[9]) check({7'h00, zero_result}, {7'h00, e[8]});
		if (!mem) begin
			check({7'h00, reg_write}, {7'h00, e[12]});
			if (e[12]) check(reg_result, e[7:0]);
		end else begin
			check(8'(bit_memory_model_inst.writes - w0), {7'h00, e[12]});
			if (e[12]) check(bit_memory_model_inst.store[a], e[7:0]);
		end
	endtask : run_op

	task automatic reg_all_ops;
		for (int o = 0; o < 14; o++) begin
			for (int k = 0; k < 8; k++) begin
				// Register position is the far end, so a wrong source shows
				run_op(o, 1'b1, k[0] ? 3'h7 : 3'h0, k[0] ? 3'h0 : 3'h7, 1'b0,
					k[2] ? 8'hA5 : 8'h5A, 8'h00, k[1]);
			end
		end
	endtask : reg_all_ops

	task automatic mem_all_ops;
		for (int o = 0; o < 14; o++) begin
			slow <= o[0];
			run_op(o, 1'b0, 3'(o), 3'h0, 1'b1, bit_memory_model_inst.store[8'h10 + o],
				8'(8'h10 + o), o[1]);
		end
	endtask : mem_all_ops

	task automatic write_only_clear;
		// Read of the write-only byte must be taken as all ones
		run_op(1, 1'b0, 3'h0, 3'h0, 1'b1, 8'hFF, 8'h30, 1'b0);
	endtask : write_only_clear

	initial begin
		repeat (6) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		#1;
		check({7'h00, ready}, 8'h01);
		reg_all_ops();
		mem_all_ops();
		write_only_clear();
		report_and_stop();
	end

	initial begin
		#100000;
		mismatches++;
		report_and_stop();
	end
endmodule : bit_manipulation_unit_tb
`default_nettype wire
